// ==== asu_consts.svh ====
// constants of the asynchronous serial channel
`ifndef ASU_CONSTS_SVH
`define ASU_CONSTS_SVH
`define ASU_DATA_W 9
`define ASU_OS_RATE 4'hf
`define ASU_OS_HALF 4'h7
`define ASU_PRE_DIV8 5'h07
`define ASU_PRE_DIV32 5'h1f
`define ASU_OVR_BIT 4'h6
`define ASU_LEN7 4'h7
`define ASU_LEN8 4'h8
`define ASU_LEN9 4'h9
`define ASU_FIFO_DEPTH 8
`define ASU_RST_LINE 1'b1
`endif

// ==== asu_pkg.sv ====
// types of the asynchronous serial channel
`include "asu_consts.svh"
`default_nettype none
package asu_pkg;
  typedef enum logic [1:0] {ASU_SRC_F1, ASU_SRC_F8, ASU_SRC_F32}
    asu_src_type;
  typedef enum logic [1:0] {ASU_LEN_7, ASU_LEN_8, ASU_LEN_9} asu_len_type;
  typedef enum logic [1:0] {ASU_FLOW_OFF, ASU_FLOW_CTS, ASU_FLOW_RTS}
    asu_flow_type;
  typedef enum logic [2:0] {ASU_IDLE, ASU_START, ASU_DATA, ASU_PARITY,
    ASU_STOP} asu_st_type;

  typedef struct packed {
    logic clk_sel;
    asu_src_type src_sel;
    logic [7:0] divisor;
    asu_len_type char_len;
    logic parity_en;
    logic parity_odd;
    logic stop_two;
    asu_flow_type flow_mode;
    logic tx_irq_sel;
    logic data_invert;
    logic line_invert;
    logic open_drain;
  } asu_cfg_type;

  typedef struct packed {
    logic overrun;
    logic framing;
    logic parity;
    logic error_sum;
  } asu_err_type;

  typedef struct packed {
    logic [4:0] pre_cnt;
    logic ext_q;
    logic [7:0] div_cnt;
    asu_st_type tx_st;
    logic [`ASU_DATA_W-1:0] tx_buf;
    logic tx_buf_empty;
    logic [`ASU_DATA_W-1:0] tx_sh;
    logic [3:0] tx_bit;
    logic [3:0] tx_os;
    logic tx_line;
    logic tx_par;
    logic tx_irq;
    asu_st_type rx_st;
    logic [3:0] rx_bit;
    logic [3:0] rx_os;
    logic [`ASU_DATA_W-1:0] rx_sh;
    logic rx_par;
    logic rx_ovf;
    logic [`ASU_DATA_W-1:0] rx_data;
    logic rx_full;
    logic rx_irq;
    logic ovr;
    logic fer;
    logic per;
    logic rts;
  } asu_state_type;
endpackage : asu_pkg
`default_nettype wire

// ==== asu_remote.sv ====
// remote serial transceiver on the line pins
`default_nettype none
module asu_remote (
  input wire logic clk,
  input wire asu_pkg::asu_cfg_type cfg,
  input wire logic line_in,
  output logic line_out,
  output logic got,
  output logic [9:0] got_word
);
  timeunit 1ns;
  timeprecision 1ps;
  int bitc = 32;
  logic raw = 1'b1;
  logic [8:0] w;
  logic ok;
  // sampled copy, so a polarity change cannot spike a false edge
  logic lv = 1'b1;
  wire [3:0] n = 4'h7 + 4'(cfg.char_len);
  assign line_out = raw ^ cfg.line_invert;
  initial got = 1'b0;
  always @(posedge clk) lv <= line_in ^ cfg.line_invert;
  task automatic put(input logic b);
    raw <= b;
    repeat (bitc) @(posedge clk);
  endtask : put
  task automatic send(input logic [8:0] d, input logic bp, bs);
    put(1'b0);
    for (int i = 0; i < n; i++) begin
      put(d[i]);
    end
    if (cfg.parity_en) put(^d ^ cfg.parity_odd ^ bp);
    put(!bs);
    // a broken stop is followed by idle so the line recovers
    if (cfg.stop_two || bs) put(1'b1);
  endtask : send
  always begin
    @(negedge lv);
    repeat (bitc / 2) @(posedge clk);
    // a spike shorter than half a bit fails this recheck
    if (!lv) begin
      ok = 1'b1;
      w = '0;
      for (int i = 0; i < n; i++) begin
        repeat (bitc) @(posedge clk);
        w[i] = lv;
      end
      if (cfg.parity_en) begin
        repeat (bitc) @(posedge clk);
        ok &= lv == (^w ^ cfg.parity_odd);
      end
      for (int i = 0; i <= cfg.stop_two; i++) begin
        repeat (bitc) @(posedge clk);
        ok &= lv;
      end
      got_word <= {!ok, w};
      got <= 1'b1;
      @(posedge clk);
      got <= 1'b0;
    end
  end
endmodule : asu_remote
`default_nettype wire

// ==== asu_sva.sv ====
// port assertions for the serial channel
`default_nettype none
module asu_sva (
  input wire logic clk,
  input wire logic sys_rst,
  input wire asu_pkg::asu_cfg_type cfg,
  input wire logic transmit_enable_bit,
  input wire logic cts_in,
  input wire logic transmit_buffer_empty_flag,
  input wire logic tx_irq,
  input wire logic rx_full,
  input wire logic rx_irq,
  input wire asu_pkg::asu_err_type err,
  input wire logic serial_data_output,
  input wire logic rts_out
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  property p_idle;
    $fell(sys_rst) && !cfg.line_invert |-> serial_data_output;
  endproperty
  a_idle: assert property (p_idle)
    else $error("line not high after reset");
  property p_go;
    $rose(transmit_buffer_empty_flag) |-> $past(transmit_enable_bit) &&
      ($past(cfg.flow_mode) != asu_pkg::ASU_FLOW_CTS || $past(cts_in));
  endproperty
  a_go: assert property (p_go)
    else $error("send started without permission");
  property p_start;
    $rose(transmit_buffer_empty_flag) && !cfg.line_invert |->
      !serial_data_output [*8];
  endproperty
  a_start: assert property (p_start)
    else $error("start bit not low");
  property p_tirq;
    $rose(transmit_buffer_empty_flag) && !cfg.tx_irq_sel |-> tx_irq;
  endproperty
  a_tirq: assert property (p_tirq)
    else $error("no transmit request at load");
  property p_rirq;
    rx_irq |-> rx_full;
  endproperty
  a_rirq: assert property (p_rirq)
    else $error("receive request with empty buffer");
  property p_sum;
    err.error_sum == (err.overrun || err.framing || err.parity);
  endproperty
  a_sum: assert property (p_sum)
    else $error("error sum wrong");
  property p_ovr;
    $rose(err.overrun) |-> !rx_irq && rx_full;
  endproperty
  a_ovr: assert property (p_ovr)
    else $error("overrun with bad request or buffer");
  property p_rts;
    $past(cfg.flow_mode) != asu_pkg::ASU_FLOW_RTS |-> !rts_out;
  endproperty
  a_rts: assert property (p_rts)
    else $error("ready output outside its mode");
endmodule : asu_sva
bind asu_uart asu_sva chk_u (.clk, .sys_rst, .cfg, .transmit_enable_bit,
  .cts_in, .transmit_buffer_empty_flag, .tx_irq, .rx_full, .rx_irq, .err,
  .serial_data_output, .rts_out);
`default_nettype wire

// ==== asu_uart.sv ====
// asynchronous serial channel with transmit fifo
`include "asu_consts.svh"
`default_nettype none

module asu_fifo #(
  parameter int WIDTH = `ASU_DATA_W,
  parameter int DEPTH = `ASU_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } asu_fifo_state_type;
  asu_fifo_state_type s_r, s_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  assign in_ready = (s_r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s_r.cnt != '0);
  assign out_data = mem[s_r.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.wp = (s_r.wp == AW'(DEPTH-1)) ? '0 : s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = (s_r.rp == AW'(DEPTH-1)) ? '0 : s_r.rp + 1'b1;
    end
    if (push && !pop) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end else if (pop && !push) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
    if (push) begin
      mem[s_r.wp] <= in_data;
    end
  end
endmodule : asu_fifo

// Overview of operation
// - one start bit, then 7/8/9 character bits
// - optional odd or even parity after character
// - one or two stop bits
// - internal: prescaled clock over 16(m+1)
// - external pin clock over 16, over m+1
// - eight-bit divisor, full range 00 to ff
// - flow control: cts, rts, or off
// - send needs enable, loaded buffer, cts ok
// - receive needs enable and detected start bit
// - transmit request at load or at finish
// - receive request when buffer gets character
// - overrun at seventh bit, buffer unread
// - overrun leaves receive request untouched
// - framing error when stop bits missing
// - parity error on ones-count mismatch
// - error sum is or of errors
// - data inversion touches character bits only
// - line inversion flips all line levels
// - output high before first transfer, or floats
// - data inverted on buffer write and read
module asu_uart (
  input wire logic clk,
  input wire logic sys_rst,
  input wire asu_pkg::asu_cfg_type cfg,
  input wire logic transmit_enable_bit,
  input wire logic receive_enable_bit,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [`ASU_DATA_W-1:0] tx_data,
  output logic transmit_buffer_empty_flag,
  output logic tx_irq,
  output logic [`ASU_DATA_W-1:0] rx_data,
  output logic rx_full,
  input wire logic rx_read,
  output logic rx_irq,
  input wire logic err_clr,
  output asu_pkg::asu_err_type err,
  input wire logic external_clock_pin,
  input wire logic serial_data_input,
  output logic serial_data_output,
  output logic serial_data_output_oe,
  input wire logic cts_in,
  output logic rts_out
);
  asu_pkg::asu_state_type s_r, s_nxt;
  logic f_valid, f_ready;
  logic [`ASU_DATA_W-1:0] f_data;
  logic src_tick, os_tick, rx_in, cts_ok, tx_end, rx_end;
  logic [3:0] nbits;

  function automatic logic [3:0] char_bits(input asu_pkg::asu_len_type l);
    case (l)
      asu_pkg::ASU_LEN_7: char_bits = `ASU_LEN7;
      asu_pkg::ASU_LEN_9: char_bits = `ASU_LEN9;
      default: char_bits = `ASU_LEN8;
    endcase
  endfunction : char_bits

  asu_fifo #(
    .WIDTH(`ASU_DATA_W),
    .DEPTH(`ASU_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_data),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  // the fifo only drains while the transmit buffer is empty
  assign f_ready = s_r.tx_buf_empty;
  assign nbits = char_bits(cfg.char_len);
  assign rx_in = serial_data_input ^ cfg.line_invert;
  assign cts_ok = (cfg.flow_mode != asu_pkg::ASU_FLOW_CTS) || cts_in;

  always_comb begin
    s_nxt = s_r;
    s_nxt.tx_irq = 1'b0;
    s_nxt.rx_irq = 1'b0;
    // count source: prescaled system clock or pin edge
    s_nxt.pre_cnt = s_r.pre_cnt + 1'b1;
    s_nxt.ext_q = external_clock_pin;
    if (cfg.clk_sel) begin
      src_tick = external_clock_pin && !s_r.ext_q;
    end else if (cfg.src_sel == asu_pkg::ASU_SRC_F8) begin
      src_tick = (s_r.pre_cnt[2:0] == 3'(`ASU_PRE_DIV8));
    end else if (cfg.src_sel == asu_pkg::ASU_SRC_F32) begin
      src_tick = (s_r.pre_cnt == `ASU_PRE_DIV32);
    end else begin
      src_tick = 1'b1;
    end
    // divide by m+1 gives the sixteen-times oversampling tick
    os_tick = 1'b0;
    if (src_tick) begin
      if (s_r.div_cnt == 8'h00) begin
        os_tick = 1'b1;
        s_nxt.div_cnt = cfg.divisor;
      end else begin
        s_nxt.div_cnt = s_r.div_cnt - 1'b1;
      end
    end

    // transmit buffer: fill from fifo, character bits inverted on write
    if (f_valid && s_r.tx_buf_empty) begin
      s_nxt.tx_buf = f_data ^ {`ASU_DATA_W{cfg.data_invert}};
      s_nxt.tx_buf_empty = 1'b0;
    end

    // transmitter
    tx_end = os_tick && (s_r.tx_os == `ASU_OS_RATE);
    if (os_tick && s_r.tx_st != asu_pkg::ASU_IDLE) begin
      s_nxt.tx_os = s_r.tx_os + 1'b1;
    end
    case (s_r.tx_st)
      asu_pkg::ASU_IDLE: begin
        s_nxt.tx_line = 1'b1;
        if (transmit_enable_bit && !s_r.tx_buf_empty && cts_ok) begin
          s_nxt.tx_sh = s_r.tx_buf;
          s_nxt.tx_buf_empty = 1'b1;
          s_nxt.tx_irq = !cfg.tx_irq_sel;
          s_nxt.tx_st = asu_pkg::ASU_START;
          s_nxt.tx_os = 4'h0;
          s_nxt.tx_line = 1'b0;
        end
      end
      asu_pkg::ASU_START: begin
        if (tx_end) begin
          s_nxt.tx_st = asu_pkg::ASU_DATA;
          s_nxt.tx_bit = 4'h0;
          s_nxt.tx_par = 1'b0;
          s_nxt.tx_line = s_r.tx_sh[0];
        end
      end
      asu_pkg::ASU_DATA: begin
        if (tx_end) begin
          s_nxt.tx_par = s_r.tx_par ^ s_r.tx_sh[s_r.tx_bit];
          s_nxt.tx_bit = s_r.tx_bit + 1'b1;
          if (s_r.tx_bit + 1'b1 == nbits) begin
            if (cfg.parity_en) begin
              s_nxt.tx_st = asu_pkg::ASU_PARITY;
              s_nxt.tx_line = s_r.tx_par ^ s_r.tx_sh[s_r.tx_bit] ^
                cfg.parity_odd;
            end else begin
              s_nxt.tx_st = asu_pkg::ASU_STOP;
              s_nxt.tx_bit = 4'h0;
              s_nxt.tx_line = 1'b1;
            end
          end else begin
            s_nxt.tx_line = s_r.tx_sh[s_r.tx_bit + 1'b1];
          end
        end
      end
      asu_pkg::ASU_PARITY: begin
        if (tx_end) begin
          s_nxt.tx_st = asu_pkg::ASU_STOP;
          s_nxt.tx_bit = 4'h0;
          s_nxt.tx_line = 1'b1;
        end
      end
      asu_pkg::ASU_STOP: begin
        if (tx_end) begin
          if (cfg.stop_two && s_r.tx_bit == 4'h0) begin
            s_nxt.tx_bit = 4'h1;
          end else begin
            s_nxt.tx_st = asu_pkg::ASU_IDLE;
            s_nxt.tx_irq = cfg.tx_irq_sel;
          end
        end
      end
      default: s_nxt.tx_st = asu_pkg::ASU_IDLE;
    endcase

    // software clear loses to a same-cycle error set below
    if (err_clr) begin
      s_nxt.ovr = 1'b0;
      s_nxt.fer = 1'b0;
      s_nxt.per = 1'b0;
    end
    // receiver
    if (rx_read) begin
      s_nxt.rx_full = 1'b0;
    end
    rx_end = os_tick && (s_r.rx_os == `ASU_OS_RATE);
    if (os_tick && s_r.rx_st != asu_pkg::ASU_IDLE) begin
      s_nxt.rx_os = s_r.rx_os + 1'b1;
    end
    case (s_r.rx_st)
      asu_pkg::ASU_IDLE: begin
        if (receive_enable_bit && os_tick && !rx_in) begin
          s_nxt.rx_st = asu_pkg::ASU_START;
          s_nxt.rx_os = 4'h0;
        end
      end
      asu_pkg::ASU_START: begin
        // half a bit later: recheck low so glitches do not start a frame
        if (os_tick && s_r.rx_os == `ASU_OS_HALF) begin
          s_nxt.rx_os = 4'h0;
          s_nxt.rx_st = rx_in ? asu_pkg::ASU_IDLE : asu_pkg::ASU_DATA;
          s_nxt.rx_bit = 4'h0;
          s_nxt.rx_sh = '0;
          s_nxt.rx_par = 1'b0;
          s_nxt.rx_ovf = 1'b0;
        end
      end
      asu_pkg::ASU_DATA: begin
        if (rx_end) begin
          s_nxt.rx_sh[s_r.rx_bit] = rx_in;
          s_nxt.rx_par = s_r.rx_par ^ rx_in;
          s_nxt.rx_bit = s_r.rx_bit + 1'b1;
          if (s_r.rx_bit == `ASU_OVR_BIT && s_r.rx_full && !rx_read) begin
            s_nxt.ovr = 1'b1;
            s_nxt.rx_ovf = 1'b1;
          end
          if (s_r.rx_bit + 1'b1 == nbits) begin
            s_nxt.rx_st = cfg.parity_en ? asu_pkg::ASU_PARITY
                                        : asu_pkg::ASU_STOP;
            s_nxt.rx_bit = 4'h0;
          end
        end
      end
      asu_pkg::ASU_PARITY: begin
        if (rx_end) begin
          if ((s_r.rx_par ^ rx_in) != cfg.parity_odd) begin
            s_nxt.per = 1'b1;
          end
          s_nxt.rx_st = asu_pkg::ASU_STOP;
        end
      end
      asu_pkg::ASU_STOP: begin
        if (rx_end) begin
          if (!rx_in) begin
            s_nxt.fer = 1'b1;
          end
          if (cfg.stop_two && s_r.rx_bit == 4'h0) begin
            s_nxt.rx_bit = 4'h1;
          end else begin
            s_nxt.rx_st = asu_pkg::ASU_IDLE;
            // an overrun frame keeps the old buffer and request state
            if (!s_r.rx_ovf) begin
              s_nxt.rx_data = s_r.rx_sh ^
                {`ASU_DATA_W{cfg.data_invert}};
              s_nxt.rx_full = 1'b1;
              s_nxt.rx_irq = 1'b1;
            end
          end
        end
      end
      default: s_nxt.rx_st = asu_pkg::ASU_IDLE;
    endcase
    if (!receive_enable_bit) begin
      s_nxt.rx_st = asu_pkg::ASU_IDLE;
    end

    // rts mode only: ready to receive while enabled and buffer free, low in other modes
    s_nxt.rts = (cfg.flow_mode == asu_pkg::ASU_FLOW_RTS) ?
      (receive_enable_bit && !s_nxt.rx_full) : 1'b0;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_r <= '0;
      s_r.tx_buf_empty <= 1'b1;
      s_r.tx_line <= `ASU_RST_LINE;
      s_r.tx_st <= asu_pkg::ASU_IDLE;
      s_r.rx_st <= asu_pkg::ASU_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign transmit_buffer_empty_flag = s_r.tx_buf_empty;
  assign tx_irq = s_r.tx_irq;
  assign rx_irq = s_r.rx_irq;
  assign rx_data = s_r.rx_data;
  assign rx_full = s_r.rx_full;
  assign rts_out = s_r.rts;
  assign err = {s_r.ovr, s_r.fer, s_r.per,
    s_r.ovr || s_r.fer || s_r.per};
  assign serial_data_output = s_r.tx_line ^ cfg.line_invert;
  // open drain: only a low level is driven, a high floats
  assign serial_data_output_oe = !cfg.open_drain ||
    !serial_data_output;
endmodule : asu_uart
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the serial channel
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  asu_pkg::asu_cfg_type cfg = '0, c;
  asu_pkg::asu_err_type err;
  logic clk = 0, sys_rst = 1, te = 1, re = 1, tx_valid = 0, rx_read = 0;
  logic err_clr = 0, ext = 0, cts = 1, no_read = 0;
  logic tx_ready, empty, tx_irq, rx_full, rx_irq, sdo, oe, rts, sdi, got;
  logic [8:0] tx_data = 0, rx_data, w;
  logic [9:0] got_word, last, held, e_tx;
  logic [9:0] exp_tx[$], exp_rx[$];
  logic [31:0] seed = 98;
  int n_mismatch = 0, cmp_count = 0, k, b, n_tirq = 0;
  wire line = oe ? sdo : 1'b1;
  asu_uart dut_u (.clk, .sys_rst, .cfg, .transmit_enable_bit(te),
    .receive_enable_bit(re), .tx_valid, .tx_ready, .tx_data,
    .transmit_buffer_empty_flag(empty), .tx_irq, .rx_data, .rx_full,
    .rx_read, .rx_irq, .err_clr, .err, .external_clock_pin(ext),
    .serial_data_input(sdi), .serial_data_output(sdo),
    .serial_data_output_oe(oe), .cts_in(cts), .rts_out(rts));
  asu_remote p_u (.clk, .cfg, .line_in(line), .line_out(sdi), .got,
    .got_word);
  initial forever #2 clk = !clk;
  always begin
    repeat (2) @(posedge clk);
    ext <= !ext;
  end
  function automatic logic [8:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[8:0];
  endfunction : rnd
  function automatic logic [8:0] msk();
    return 9'h1ff >> (2 - int'(cfg.char_len));
  endfunction : msk
  task automatic chk(input logic [9:0] s, e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic results();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results
  task automatic rst();
    sys_rst <= 1'b1;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
  endtask : rst
  task automatic setc(input int bc);
    cfg <= c;
    p_u.bitc = bc;
    @(posedge clk);
  endtask : setc
  task automatic push(input int cnt);
    k = 0;
    w = rnd();
    tx_data <= w;
    tx_valid <= 1'b1;
    repeat (cnt) begin
      @(posedge clk);
      if (tx_ready) begin
        k++;
        exp_tx.push_back({1'b0, (cfg.data_invert ? ~w : w) & msk()});
        w = rnd();
        tx_data <= w;
      end
    end
    tx_valid <= 1'b0;
  endtask : push
  task automatic rx(input logic bp, bs, e);
    logic [8:0] r;
    r = rnd() & msk();
    last = {1'b0, cfg.data_invert ? ~r : r};
    if (e) exp_rx.push_back(last);
    p_u.send(r, bp, bs);
  endtask : rx
  task automatic drain();
    repeat (50000) if (exp_tx.size() + exp_rx.size() != 0) @(posedge clk);
    repeat (2 * p_u.bitc) @(posedge clk);
  endtask : drain
  task automatic clr();
    err_clr <= 1'b1;
    @(posedge clk);
    err_clr <= 1'b0;
    @(posedge clk);
    chk(10'(err), 10'h000);
  endtask : clr
  always @(posedge clk) begin
    rx_read <= rx_irq && !no_read;
    if (tx_irq) n_tirq++;
    if (rx_irq && exp_rx.size() != 0) begin
      chk({1'b0, rx_data}, exp_rx.pop_front());
    end
    if (got) begin
      // an unexpected frame must not pass against an empty queue
      e_tx = exp_tx.size() != 0 ? exp_tx.pop_front() : ~got_word;
      chk(got_word, e_tx);
    end
  end
  initial begin
    // the full sequence needs roughly 85 percent of this
    repeat (96000) @(posedge clk);
    n_mismatch++;
    results();
  end
  initial begin
    rst();
    for (int i = 0; i < 8; i++) begin
      c = '0;
      c.char_len = asu_pkg::asu_len_type'((i + 1) % 3);
      c.src_sel = asu_pkg::asu_src_type'(i % 3);
      c.clk_sel = i == 7;
      c.divisor = i == 6 ? 8'hff : 8'(i / 3);
      c.parity_en = i[0];
      c.parity_odd = i[1];
      c.stop_two = i[1] && i != 6;
      c.flow_mode = asu_pkg::asu_flow_type'(i % 3);
      c.tx_irq_sel = i[0];
      c.data_invert = i[1];
      c.line_invert = i == 4;
      c.open_drain = i == 5;
      b = c.clk_sel ? 4 : c.src_sel == 0 ? 1 : c.src_sel == 1 ? 8 : 32;
      setc(16 * (c.divisor + 1) * b);
      fork
        push(1);
        rx(0, 0, 1);
      join
      drain();
      if (c.flow_mode == asu_pkg::ASU_FLOW_RTS) begin
        chk({9'h0, rts}, 10'h001);
      end
    end
    c = '0;
    c.char_len = asu_pkg::ASU_LEN_8;
    c.divisor = 8'h01;
    setc(32);
    te <= 1'b0;
    push(12);
    chk(10'(k), 10'h009);
    chk({9'h0, empty}, 10'h000);
    te <= 1'b1;
    drain();
    c.flow_mode = asu_pkg::ASU_FLOW_CTS;
    setc(32);
    cts <= 1'b0;
    push(1);
    repeat (64) @(posedge clk);
    chk({9'h0, empty}, 10'h000);
    cts <= 1'b1;
    drain();
    c.parity_en = 1'b1;
    setc(32);
    rx(1, 0, 0);
    chk(10'(err), 10'h003);
    clr();
    rx(0, 1, 0);
    chk(10'(err), 10'h005);
    clr();
    no_read <= 1'b1;
    re <= 1'b0;
    rx(0, 0, 0);
    chk({9'h0, rx_full}, 10'h000);
    re <= 1'b1;
    rx(0, 0, 1);
    held = last;
    rx(0, 0, 0);
    chk(10'(err), 10'h009);
    chk({1'b0, rx_data}, held);
    chk(10'(n_tirq), 10'h012);
    rst();
    repeat (2) @(posedge clk);
    chk({3'h0, sdo, empty, rx_full, err}, 10'h060);
    results();
  end
endmodule : tb_top
`default_nettype wire
